// *** logic/seep_pkg.sv ***
package seep_pkg;
	// Serial command codes
	localparam logic [7:0] CMD_SET_WRITE_LATCH = 8'h06;
	localparam logic [7:0] CMD_CLEAR_WRITE_LATCH = 8'h04;
	localparam logic [7:0] CMD_STATUS_READ = 8'h05;
	localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
	localparam logic [7:0] CMD_ARRAY_READ = 8'h03;
	localparam logic [7:0] CMD_ARRAY_WRITE = 8'h02;
	localparam logic [7:0] CMD_ID_PAGE_READ = 8'h83;
	localparam logic [7:0] CMD_ID_PAGE_WRITE = 8'h82;
	// Byte counts: header length, least write frame length and byte counter cap; then the last bit index of a byte
	localparam logic [2:0] HDR_STATUS = 3'h1;
	localparam logic [2:0] HDR_ADDR = 3'h4;
	localparam logic [2:0] MIN_STATUS_WRITE = 3'h2;
	localparam logic [2:0] MIN_ARRAY_WRITE = 3'h5;
	localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
	localparam logic [2:0] BIT_LAST = 3'h7;
	// Address bit that selects the lock state over the id page
	localparam int LOCK_SEL_BIT = 10;
	// Status bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_BP_LO = 2;
	localparam int ST_BP_HI = 3;
	localparam int ST_LOCK = 7;
	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	localparam logic [1:0] BP_ALL = 2'h3;
	localparam logic [1:0] BP_RESET = 2'h0;
	localparam logic LOCK_RESET = 1'b0;
	// Internal write time
	localparam int WRITE_TIME_US = 5000;
	localparam int REF_CLK_MHZ = 40;
	localparam int WRITE_CYCLES = WRITE_TIME_US * REF_CLK_MHZ;
	localparam int TIMER_W = 18;

	typedef struct packed {
		logic status_lock_bit;
		logic [2:0] unused;
		logic block_protect_hi;
		logic block_protect_lo;
		logic write_enable_latch;
		logic busy_flag;
	} seep_status_s;

	typedef struct packed {
		logic [7:0] opcode;
		logic [23:0] addr;
		logic [7:0] data;
		logic [2:0] byte_cnt;
		logic [2:0] bit_cnt;
		logic bad;
	} seep_frame_s;

	typedef enum logic [2:0] {
		WR_IDLE = 3'b001,
		WR_STATUS = 3'b010,
		WR_ARRAY = 3'b100
	} seep_wr_e;
endpackage

// *** logic/seep_sync.sv ***
`timescale 1ns/1ps
module seep_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	input wire logic [WIDTH-1:0] rst_val,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_reg <= rst_val;
			q <= rst_val;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule // seep_sync

// *** logic/seep_front_end.sv ***
`timescale 1ns/1ps
module seep_front_end
	import seep_pkg::*;
#(
	parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	input wire logic spi_hold_n,
	input wire logic spi_wp_n,
	input wire logic [7:0] mem_rd_data,
	output logic spi_so,
	output logic spi_so_oe,
	output logic [23:0] mem_addr,
	output logic standby,
	output logic array_write_start,
	output logic [17:0] array_write_addr,
	output seep_status_s status_protection
);
	// Link side, clocked by the serial clock
	seep_frame_s frame_reg;
	logic active_reg;
	logic [6:0] shift_reg;
	logic [7:0] byte_in;
	logic [2:0] bit_now;
	logic [2:0] byte_now;
	logic byte_done;
	logic so_reg;
	logic out_en_reg;
	logic pause_reg;
	logic paused;
	logic sending;
	logic is_rd_addr;
	logic [7:0] out_src;
	seep_status_s status_link;
	// Reference side
	logic [2:0] pins_sync;
	logic cs_sync;
	logic hold_sync;
	logic wp_sync;
	logic cs_prev_reg;
	logic cs_rise;
	logic armed_reg;
	logic frozen;
	logic commit;
	logic aligned;
	logic protected_hit;
	seep_wr_e wr_reg;
	logic [TIMER_W-1:0] timer_reg;
	logic [2:0] pend_reg;
	logic wel_reg;
	logic lock_reg;
	logic [1:0] bp_reg;

	function automatic logic opcode_ok(input logic [7:0] op);
		case (op)
			CMD_SET_WRITE_LATCH, CMD_CLEAR_WRITE_LATCH, CMD_STATUS_READ,
			CMD_STATUS_WRITE, CMD_ARRAY_READ, CMD_ARRAY_WRITE,
			CMD_ID_PAGE_READ, CMD_ID_PAGE_WRITE: opcode_ok = 1'b1;
			default: opcode_ok = 1'b0;
		endcase
	endfunction

	always_ff @(posedge spi_clk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			active_reg <= 1'b0;
		end else if (spi_hold_n) begin
			active_reg <= 1'b1;
		end
	end

	assign bit_now = active_reg ? frame_reg.bit_cnt : 3'h0;
	assign byte_now = active_reg ? frame_reg.byte_cnt : 3'h0;
	assign byte_done = (bit_now == BIT_LAST);
	assign byte_in = {(active_reg ? shift_reg : 7'h00), spi_si};

	always_ff @(posedge spi_clk) begin
		if (spi_hold_n) begin
			shift_reg <= byte_in[6:0];
			frame_reg.bit_cnt <= bit_now + 3'h1;
			if (!active_reg) begin
				frame_reg.bad <= 1'b0;
			end
			frame_reg.byte_cnt <= byte_now;
			if (byte_done) begin
				if (byte_now != BYTE_CNT_MAX) begin
					frame_reg.byte_cnt <= byte_now + 3'h1;
				end
				case (byte_now)
					3'h0: begin
						frame_reg.opcode <= byte_in;
						frame_reg.bad <= !opcode_ok(byte_in);
					end
					3'h1: frame_reg.addr[23:16] <= byte_in;
					3'h2: frame_reg.addr[15:8] <= byte_in;
					3'h3: frame_reg.addr[7:0] <= byte_in;
					default: frame_reg.addr <= frame_reg.addr;
				endcase
				if ((frame_reg.opcode == CMD_STATUS_WRITE && byte_now == 3'h1)
						|| byte_now == HDR_ADDR) begin
					frame_reg.data <= byte_in;
				end
			end
		end
	end

	// Status word is quasi-static; a byte changing mid-frame may read stale
	seep_sync #(.WIDTH(8)) u_status_sync (
		.clk(spi_clk),
		.rst_n(1'b1),
		.d(status_protection),
		.rst_val(8'h00),
		.q(status_link)
	);

	assign is_rd_addr = (frame_reg.opcode == CMD_ARRAY_READ)
		|| (frame_reg.opcode == CMD_ID_PAGE_READ);
	assign sending = !frame_reg.bad
		&& (((frame_reg.opcode == CMD_STATUS_READ)
		&& (frame_reg.byte_cnt >= HDR_STATUS))
		|| (is_rd_addr && (frame_reg.byte_cnt >= HDR_ADDR)));
	assign out_src = (frame_reg.opcode == CMD_STATUS_READ) ? status_link
		: mem_rd_data;

	always_ff @(negedge spi_clk) begin
		pause_reg <= !spi_hold_n;
		if (spi_hold_n) begin
			so_reg <= out_src[~frame_reg.bit_cnt];
			out_en_reg <= sending;
		end
	end

	assign paused = !spi_hold_n && (!spi_clk || pause_reg);
	assign spi_so_oe = out_en_reg && active_reg && !spi_cs_n && !paused
		&& armed_reg;
	assign spi_so = so_reg;
	assign mem_addr = frame_reg.addr;

	seep_sync #(.WIDTH(3)) u_pin_sync (
		.clk(ref_clk),
		.rst_n(resetn),
		.d({spi_cs_n, spi_hold_n, spi_wp_n}),
		.rst_val(3'h7),
		.q(pins_sync)
	);
	assign cs_sync = pins_sync[2];
	assign hold_sync = pins_sync[1];
	assign wp_sync = pins_sync[0];

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cs_prev_reg <= 1'b1;
			armed_reg <= 1'b0;
		end else begin
			cs_prev_reg <= cs_sync;
			if (cs_sync) begin
				armed_reg <= 1'b1;
			end
		end
	end

	assign cs_rise = cs_sync && !cs_prev_reg;
	assign aligned = (frame_reg.bit_cnt == 3'h0) && !frame_reg.bad;
	assign commit = cs_rise && armed_reg && hold_sync && aligned;
	assign frozen = lock_reg && !wp_sync;

	always_comb begin
		case (bp_reg)
			BP_QUARTER: protected_hit = (frame_reg.addr[17:16] == 2'h3);
			BP_HALF: protected_hit = frame_reg.addr[17];
			BP_ALL: protected_hit = 1'b1;
			default: protected_hit = 1'b0;
		endcase
		if (frame_reg.opcode == CMD_ID_PAGE_WRITE) begin
			protected_hit = (bp_reg == BP_ALL);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wr_reg <= WR_IDLE;
			timer_reg <= '0;
			array_write_start <= 1'b0;
			array_write_addr <= '0;
		end else begin
			array_write_start <= 1'b0;
			case (wr_reg)
				WR_IDLE: begin
					if (commit && wel_reg) begin
						timer_reg <= TIMER_W'(WRITE_CYCLES_P - 1);
						if (frame_reg.opcode == CMD_STATUS_WRITE
								&& frame_reg.byte_cnt >= MIN_STATUS_WRITE
								&& !frozen) begin
							wr_reg <= WR_STATUS;
						end else if ((frame_reg.opcode == CMD_ARRAY_WRITE
								|| frame_reg.opcode == CMD_ID_PAGE_WRITE)
								&& frame_reg.byte_cnt >= MIN_ARRAY_WRITE
								&& !protected_hit) begin
							wr_reg <= WR_ARRAY;
							array_write_start <= 1'b1;
							array_write_addr <= frame_reg.addr[17:0];
						end
					end
				end
				WR_STATUS, WR_ARRAY: begin
					timer_reg <= timer_reg - TIMER_W'(1);
					if (timer_reg == '0) begin
						wr_reg <= WR_IDLE;
					end
				end
				default: wr_reg <= WR_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wel_reg <= 1'b0;
		end else if (wr_reg != WR_IDLE && timer_reg == '0) begin
			wel_reg <= 1'b0;
		end else if (commit && frame_reg.opcode == CMD_CLEAR_WRITE_LATCH) begin
			wel_reg <= 1'b0;
		end else if (commit && frame_reg.opcode == CMD_SET_WRITE_LATCH
				&& wr_reg == WR_IDLE) begin
			wel_reg <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pend_reg <= {LOCK_RESET, BP_RESET};
			lock_reg <= LOCK_RESET;
			bp_reg <= BP_RESET;
		end else begin
			if (wr_reg == WR_IDLE && commit && wel_reg && !frozen
					&& frame_reg.opcode == CMD_STATUS_WRITE
					&& frame_reg.byte_cnt >= MIN_STATUS_WRITE) begin
				pend_reg <= {frame_reg.data[ST_LOCK],
					frame_reg.data[ST_BP_HI], frame_reg.data[ST_BP_LO]};
			end
			if (wr_reg == WR_STATUS && timer_reg == '0) begin
				lock_reg <= pend_reg[2];
				bp_reg <= pend_reg[1:0];
			end
		end
	end

	assign status_protection = '{status_lock_bit: lock_reg, unused: 3'h0,
		block_protect_hi: bp_reg[1], block_protect_lo: bp_reg[0],
		write_enable_latch: wel_reg, busy_flag: (wr_reg != WR_IDLE)};
	assign standby = cs_sync && (wr_reg == WR_IDLE);

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	so_off_cs_a: assert property (cs_sync |-> !spi_so_oe)
		else $error("output driven while deselected");
	standby_idle_a: assert property (standby |-> !status_protection.busy_flag)
		else $error("standby during write cycle");
	unused_zero_a: assert property (status_protection.unused == 3'h0)
		else $error("unused status bits not zero");
	busy_hold_a: assert property ($rose(status_protection.busy_flag) |-> status_protection.busy_flag [*8])
		else $error("busy dropped early");
	wel_end_a: assert property ($fell(status_protection.busy_flag) |-> !wel_reg)
		else $error("latch not cleared at write end");
	wel_needed_a: assert property ($rose(status_protection.busy_flag) |-> $past(wel_reg))
		else $error("write started without latch");
	frozen_bits_a: assert property ((frozen && wr_reg == WR_IDLE) |=> $stable(bp_reg) && $stable(lock_reg))
		else $error("protect bits changed while frozen");
	unarmed_quiet_a: assert property (!armed_reg |-> !spi_so_oe)
		else $error("output before first deselect");
	bad_no_write_a: assert property ((cs_rise && frame_reg.bad) |=> !array_write_start)
		else $error("bad opcode started a write");
	// Pause checks sample the raw pins of the link
	pause_quiet_a: assert property ((!spi_hold_n && !spi_clk) |-> !spi_so_oe)
		else $error("output driven during pause");
	clear_write_latch_cmd_clears_a: assert property ((commit && frame_reg.opcode == CMD_CLEAR_WRITE_LATCH) |=> !wel_reg)
		else $error("disable did not clear latch");
	set_write_latch_cmd_sets_a: assert property ((commit && frame_reg.opcode == CMD_SET_WRITE_LATCH && wr_reg == WR_IDLE) |=> wel_reg)
		else $error("enable did not set latch");
	mid_byte_a: assert property ((cs_rise && frame_reg.bit_cnt != 3'h0) |=> !array_write_start)
		else $error("unaligned frame started a write");
	prot_all_a: assert property (array_write_start |-> $past(bp_reg) != BP_ALL)
		else $error("write started with all blocks protected");
	standby_cs_a: assert property (!cs_sync |-> !standby)
		else $error("standby while selected");
endmodule // seep_front_end

// *** bench/seep_master.sv ***
`timescale 1ns/1ps
module seep_master (
	output logic spi_clk,
	output logic spi_cs_n,
	output logic spi_si,
	output logic spi_hold_n,
	input wire logic spi_so,
	input wire logic spi_so_oe
);
	logic line_val;
	logic last_val;
	logic hold_oe;
	logic oe_seen;
	// Released line shows the inverse of its last driven level
	assign line_val = spi_so_oe ? spi_so : ~last_val;
	always @(spi_so or spi_so_oe)
		if (spi_so_oe)
			last_val = spi_so;
	initial begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
		spi_hold_n = 1'b1;
		last_val = 1'b0;
	end
	task automatic frame(input logic [39:0] bits, input int n,
		input int hold_at, output logic [7:0] rd);
		int i;
		int k;
		rd = 8'h00;
		hold_oe = 1'b0;
		oe_seen = 1'b0;
		spi_cs_n <= 1'b0;
		for (i = 0; i < n; i++) begin
			if (i == hold_at) begin
				#40 spi_hold_n <= 1'b0;
				for (k = 0; k < 3; k++) begin
					#80 spi_clk <= 1'b1;
					spi_si <= ~spi_si;
					hold_oe = hold_oe | spi_so_oe;
					#80 spi_clk <= 1'b0;
				end
				#80 spi_hold_n <= 1'b1;
			end
			// MSB first, data changes while clock low
			spi_si <= bits[39-i];
			#80 spi_clk <= 1'b1;
			rd = {rd[6:0], line_val};
			oe_seen = oe_seen | spi_so_oe;
			#80 spi_clk <= 1'b0;
		end
		#80 spi_cs_n <= 1'b1;
		spi_si <= 1'b0;
	endtask
endmodule // seep_master

// *** bench/spi_eeprom_front_end_protect_tb.sv ***
`timescale 1ns/1ps
module spi_eeprom_front_end_protect_tb;
	import seep_pkg::*;
	logic ref_clk;
	logic resetn;
	logic spi_clk;
	logic spi_cs_n;
	logic spi_si;
	logic spi_hold_n;
	logic spi_wp_n;
	logic [7:0] mem_rd_data;
	logic spi_so;
	logic spi_so_oe;
	logic [23:0] mem_addr;
	logic standby;
	logic array_write_start;
	logic [17:0] array_write_addr;
	seep_status_s status_protection;
	int num_errors = 0;
	int check_count = 0;
	logic [31:0] seed = 32'd55;
	logic [7:0] exp_st[$];
	logic [17:0] exp_wr[$];
	logic [7:0] got_st;
	logic [7:0] junk;
	event st_ev;

	seep_front_end #(.WRITE_CYCLES_P(20)) dut_u (.ref_clk(ref_clk),
		.resetn(resetn), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
		.spi_si(spi_si), .spi_hold_n(spi_hold_n), .spi_wp_n(spi_wp_n),
		.mem_rd_data(mem_rd_data), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
		.mem_addr(mem_addr), .standby(standby),
		.array_write_start(array_write_start),
		.array_write_addr(array_write_addr),
		.status_protection(status_protection));
	seep_master m_u (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
		.spi_si(spi_si), .spi_hold_n(spi_hold_n), .spi_so(spi_so),
		.spi_so_oe(spi_so_oe));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic cmp(input logic [17:0] e, input logic [17:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic cmp_st(input logic [7:0] e, input logic [7:0] g);
		cmp({10'h000, e}, {10'h000, g});
	endtask
	task automatic cmp_wr(input logic [17:0] e, input logic [17:0] g);
		cmp(e, g);
	endtask
	task automatic cmp_flag(input logic e, input logic g);
		cmp({17'h00000, e}, {17'h00000, g});
	endtask
	always @(st_ev)
		cmp_st(exp_st.pop_front(), got_st);
	always @(posedge ref_clk)
		if (array_write_start === 1'b1)
			cmp_wr(exp_wr.size() ? exp_wr.pop_front() : 18'h3_ffff,
				array_write_addr);
	task automatic cmd(input logic [39:0] b, input int n);
		m_u.frame(b, n, 99, junk);
		#1000;
	endtask
	task automatic rd_status(input logic [7:0] e, input int hold_at);
		exp_st.push_back(e);
		m_u.frame({CMD_STATUS_READ, 32'h0000_0000}, 24, hold_at, got_st);
		->st_ev;
		#400;
	endtask
	task automatic rd_array(input logic [23:0] a, input logic [7:0] e);
		exp_st.push_back(e);
		m_u.frame({CMD_ARRAY_READ, a, 8'h00}, 40, 99, got_st);
		->st_ev;
		cmp_wr(a[17:0], mem_addr[17:0]);
		#400;
	endtask
	task automatic wr_status(input logic [7:0] v);
		cmd({CMD_SET_WRITE_LATCH, 32'h0000_0000}, 8);
		cmd({CMD_STATUS_WRITE, v, 24'h00_0000}, 16);
	endtask
	task automatic wr_array(input logic [17:0] a, input int n, input bit ok);
		cmd({CMD_SET_WRITE_LATCH, 32'h0000_0000}, 8);
		if (ok)
			exp_wr.push_back(a);
		cmd({CMD_ARRAY_WRITE, 6'h00, a, seed[7:0]}, n);
	endtask
	task automatic tally_and_finish();
		check_count++;
		if (exp_wr.size() != 0)
			num_errors++;
		$display("Checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#600000;
		num_errors++;
		$display("Watchdog expired at %0t", $time);
		tally_and_finish();
	end
	initial begin
		resetn = 1'b0;
		spi_wp_n = 1'b1;
		mem_rd_data = 8'h00;
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		#400;
		rd_status(8'h00, 99);
		cmd({CMD_SET_WRITE_LATCH, 32'h0000_0000}, 8);
		rd_status(8'h02, 12);
		cmp_flag(1'b0, m_u.hold_oe);
		cmd({CMD_CLEAR_WRITE_LATCH, 32'h0000_0000}, 8);
		rd_status(8'h00, 99);
		cmd({CMD_STATUS_WRITE, 8'h8c, 24'h00_0000}, 16);
		rd_status(8'h00, 99);
		m_u.frame({8'hff, CMD_STATUS_READ, 24'h00_0000}, 24, 99, junk);
		cmp_flag(1'b0, m_u.oe_seen);
		#400;
		$display("Test latch and pause done");
		for (int bp = 0; bp < 4; bp++) begin
			wr_status({4'h0, bp[1:0], 2'b00});
			rd_status({4'h0, bp[1:0], 2'b00}, 99);
			seed = xs(seed);
			mem_rd_data <= seed[31:24];
			#100;
			rd_array({6'h00, seed[17:0]}, seed[31:24]);
			wr_array({2'b11, seed[15:0]}, 40, bp == 0);
			wr_array({2'b00, seed[31:16]}, 40, bp != 3);
		end
		$display("Test block protect done");
		wr_status(8'h80);
		wr_array(18'h0_1234, 37, 1'b0);
		wr_array(18'h0_0042, 32, 1'b0);
		spi_wp_n <= 1'b0;
		wr_status(8'h0c);
		cmd({CMD_CLEAR_WRITE_LATCH, 32'h0000_0000}, 8);
		rd_status(8'h80, 99);
		spi_wp_n <= 1'b1;
		wr_status(8'h00);
		rd_status(8'h00, 99);
		spi_wp_n <= 1'b0;
		wr_status(8'h84);
		rd_status(8'h84, 99);
		wr_status(8'h00);
		cmd({CMD_CLEAR_WRITE_LATCH, 32'h0000_0000}, 8);
		rd_status(8'h84, 99);
		spi_wp_n <= 1'b1;
		wr_status(8'h00);
		rd_status(8'h00, 99);
		$display("Test status lock done");
		cmd({CMD_SET_WRITE_LATCH, 32'h0000_0000}, 8);
		m_u.frame({CMD_STATUS_WRITE, 32'h0000_0000}, 16, 99, junk);
		#250;
		cmp_flag(1'b0, standby);
		cmp_flag(1'b1, status_protection.busy_flag);
		#1000;
		cmp_flag(1'b1, standby);
		cmp_flag(1'b0, status_protection.busy_flag);
		$display("Test standby done");
		tally_and_finish();
	end
endmodule // spi_eeprom_front_end_protect_tb
